// ==== arlu_defines.svh ====
// What this block does
// - rotate right, bit 0 to 7, carry kept
// - rotate right through carry, both directions
// - rotate left, bit 7 to 0, carry kept
// - rotate left through carry, both directions
// - byte logic targets accumulator or RAM byte
// - and: result bit one only if both one
// - or: result bit one if either one
// - xor: result bit one if bits differ
// - carry and bit: set only if both one
// - carry and inverted bit variant
// - carry or bit: clear only if both zero
// - carry or inverted bit variant
// - carry bit logic writes carry only
// - no xor between carry and a bit
// - exchange accumulator with byte in one step
// - nibble swap equals four left rotations
// - exchange low nibbles, upper nibbles kept
// - decimal adjust yields packed BCD sum
// - half carry set by carry out of bit 3
`ifndef ARLU_DEFINES_SVH
`define ARLU_DEFINES_SVH

`define ARLU_DATA_W 8
`define ARLU_NIB_W 4
`define ARLU_OP_W 5
`define ARLU_ACC_RST 8'h00
`define ARLU_MEM_RST 8'h00
`define ARLU_CY_RST 1'b0
`define ARLU_AC_RST 1'b0
`define ARLU_BCD_MAX 4'h9
`define ARLU_DA_LO 8'h06
`define ARLU_DA_HI 8'h60
`define ARLU_HC_BIT 4

`endif

// ==== arlu_pkg.sv ====
`include "arlu_defines.svh"

package arlu_pkg;

    typedef enum logic [`ARLU_OP_W-1:0] {
        OP_NOP   = 5'h00,
        OP_RR    = 5'h01,
        OP_RRC   = 5'h02,
        OP_RL    = 5'h03,
        OP_RLC   = 5'h04,
        OP_AND   = 5'h05,
        OP_OR    = 5'h06,
        OP_XOR   = 5'h07,
        OP_ANDC  = 5'h08,
        OP_ANDNC = 5'h09,
        OP_ORC   = 5'h0A,
        OP_ORNC  = 5'h0B,
        OP_XCH   = 5'h0C,
        OP_SWAP  = 5'h0D,
        OP_LOW_NIBBLE_EXCHANGE  = 5'h0E,
        OP_DA    = 5'h0F,
        OP_ADD   = 5'h10,
        OP_ADDC  = 5'h11,
        OP_LDA   = 5'h12,
        OP_LDC   = 5'h13
    } arlu_op_t;

    typedef enum logic [1:0] {
        LG_AND = 2'h0,
        LG_OR  = 2'h1,
        LG_XOR = 2'h2
    } arlu_logic_t;

    typedef struct packed {
        logic [`ARLU_DATA_W-1:0] acc;
        logic cy;
        logic ac;
        logic [`ARLU_DATA_W-1:0] mem;
        logic mem_we;
        logic done;
    } arlu_state_t;

endpackage : arlu_pkg

// ==== arlu_bitop.sv ====
`timescale 1ns/1ps
`default_nettype none

module arlu_bitop
    import arlu_pkg::*;
#(
    parameter int W = 8
) (
    // operands
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire arlu_logic_t sel_i,
    // result
    output logic [W-1:0] y_o
);

    always_comb begin
        case (sel_i)
            LG_AND: y_o = a_i & b_i;
            LG_OR: y_o = a_i | b_i;
            LG_XOR: y_o = a_i ^ b_i;
            default: y_o = a_i;
        endcase
    end

endmodule : arlu_bitop

`default_nettype wire

// ==== arlu_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "arlu_defines.svh"

module arlu_top
    import arlu_pkg::*;
#(
    parameter int DW = `ARLU_DATA_W
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // operation request
    input wire logic op_valid_i,
    input wire arlu_op_t op_code_i,
    input wire logic [DW-1:0] opnd_i,
    input wire logic [DW-1:0] dst_i,
    input wire logic dest_mem_i,
    input wire logic bit_i,
    // accumulator and flags
    output logic [DW-1:0] acc_o,
    output logic carry_o,
    output logic half_carry_o,
    // write back to the RAM or special register side
    output logic [DW-1:0] mem_data_o,
    output logic mem_we_o,
    output logic done_o
);

    localparam int NW = `ARLU_NIB_W;

    arlu_state_t q_r;
    arlu_state_t q_nxt;

    logic take;
    arlu_logic_t byte_sel;
    arlu_logic_t bit_sel;
    logic [DW-1:0] byte_a;
    logic [DW-1:0] byte_y;
    logic bit_b;
    logic bit_y;
    logic [NW:0] add_lo;
    logic [DW:0] add_sum;
    logic add_cin;
    logic da_lo_fix;
    logic [DW:0] da_step1;
    logic da_hi_fix;
    logic [DW:0] da_step2;

    assign take = op_valid_i && ce_i;

    // one instance serves both accumulator and RAM destinations
    assign byte_a = dest_mem_i ? dst_i : q_r.acc;

    always_comb begin
        case (op_code_i)
            OP_OR: byte_sel = LG_OR;
            OP_XOR: byte_sel = LG_XOR;
            default: byte_sel = LG_AND;
        endcase
    end

    arlu_bitop #(
        .W(DW)
    ) u_byte (
        .a_i(byte_a),
        .b_i(opnd_i),
        .sel_i(byte_sel),
        .y_o(byte_y)
    );

    // carry logic only ever selects and or or; xor is unreachable here
    assign bit_sel = (op_code_i == OP_ORC || op_code_i == OP_ORNC) ? LG_OR : LG_AND;
    assign bit_b = (op_code_i == OP_ANDNC || op_code_i == OP_ORNC) ? ~bit_i : bit_i;

    arlu_bitop #(
        .W(1)
    ) u_bit (
        .a_i(q_r.cy),
        .b_i(bit_b),
        .sel_i(bit_sel),
        .y_o(bit_y)
    );

    assign add_cin = (op_code_i == OP_ADDC) ? q_r.cy : 1'b0;
    assign add_lo = {1'b0, q_r.acc[NW-1:0]} + {1'b0, opnd_i[NW-1:0]} + {{NW{1'b0}}, add_cin};
    assign add_sum = {1'b0, q_r.acc} + {1'b0, opnd_i} + {{DW{1'b0}}, add_cin};

    // two-stage correction; the second stage looks at the first stage's result
    assign da_lo_fix = (q_r.acc[NW-1:0] > `ARLU_BCD_MAX) || q_r.ac;
    assign da_step1 = {1'b0, q_r.acc} + (da_lo_fix ? {1'b0, `ARLU_DA_LO} : {(DW+1){1'b0}});
    assign da_hi_fix = (da_step1[DW-1:NW] > `ARLU_BCD_MAX) || q_r.cy || da_step1[DW];
    assign da_step2 = {1'b0, da_step1[DW-1:0]}
        + (da_hi_fix ? {1'b0, `ARLU_DA_HI} : {(DW+1){1'b0}});

    always_comb begin
        q_nxt = q_r;
        q_nxt.mem_we = 1'b0;
        q_nxt.done = 1'b0;
        if (take) begin
            q_nxt.done = 1'b1;
            case (op_code_i)
                OP_RR: q_nxt.acc = {q_r.acc[0], q_r.acc[DW-1:1]};
                OP_RRC: begin
                    q_nxt.acc = {q_r.cy, q_r.acc[DW-1:1]};
                    q_nxt.cy = q_r.acc[0];
                end
                OP_RL: q_nxt.acc = {q_r.acc[DW-2:0], q_r.acc[DW-1]};
                OP_RLC: begin
                    q_nxt.acc = {q_r.acc[DW-2:0], q_r.cy};
                    q_nxt.cy = q_r.acc[DW-1];
                end
                OP_AND, OP_OR, OP_XOR: begin
                    if (dest_mem_i) begin
                        q_nxt.mem = byte_y;
                        q_nxt.mem_we = 1'b1;
                    end else begin
                        q_nxt.acc = byte_y;
                    end
                end
                OP_ANDC, OP_ANDNC, OP_ORC, OP_ORNC: begin
                    // the addressed bit is never written back
                    q_nxt.cy = bit_y;
                end
                OP_XCH: begin
                    q_nxt.acc = dst_i;
                    q_nxt.mem = q_r.acc;
                    q_nxt.mem_we = 1'b1;
                end
                OP_SWAP: q_nxt.acc = {q_r.acc[NW-1:0], q_r.acc[DW-1:NW]};
                OP_LOW_NIBBLE_EXCHANGE: begin
                    q_nxt.acc = {q_r.acc[DW-1:NW], dst_i[NW-1:0]};
                    q_nxt.mem = {dst_i[DW-1:NW], q_r.acc[NW-1:0]};
                    q_nxt.mem_we = 1'b1;
                end
                OP_DA: begin
                    q_nxt.acc = da_step2[DW-1:0];
                    // adjust only ever sets carry, never clears it
                    q_nxt.cy = q_r.cy | da_step1[DW] | da_step2[DW];
                end
                OP_ADD, OP_ADDC: begin
                    q_nxt.acc = add_sum[DW-1:0];
                    q_nxt.cy = add_sum[DW];
                    q_nxt.ac = add_lo[NW];
                end
                OP_LDA: q_nxt.acc = opnd_i;
                OP_LDC: q_nxt.cy = bit_i;
                default: q_nxt.done = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_r.acc <= `ARLU_ACC_RST;
            q_r.cy <= `ARLU_CY_RST;
            q_r.ac <= `ARLU_AC_RST;
            q_r.mem <= `ARLU_MEM_RST;
            q_r.mem_we <= 1'b0;
            q_r.done <= 1'b0;
        end else if (ce_i) begin
            q_r <= q_nxt;
        end
    end

    assign acc_o = q_r.acc;
    assign carry_o = q_r.cy;
    assign half_carry_o = q_r.ac;
    assign mem_data_o = q_r.mem;
    assign mem_we_o = q_r.mem_we;
    assign done_o = q_r.done;

    // checks

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence take_op(arlu_op_t o);
        take && op_code_i == o;
    endsequence

    sequence rl_four;
        take_op(OP_RL) ##1 take_op(OP_RL) ##1 take_op(OP_RL) ##1 take_op(OP_RL);
    endsequence

    rot_right_a: assert property (take_op(OP_RR) |=>
        acc_o == {$past(acc_o[0]), $past(acc_o[DW-1:1])} && carry_o == $past(carry_o))
        else $error("rotate right wrong");

    rot_right_cy_a: assert property (take_op(OP_RRC) |=>
        acc_o == {$past(carry_o), $past(acc_o[DW-1:1])} && carry_o == $past(acc_o[0]))
        else $error("rotate right through carry wrong");

    rot_left_a: assert property (take_op(OP_RL) |=>
        acc_o == {$past(acc_o[DW-2:0]), $past(acc_o[DW-1])} && carry_o == $past(carry_o))
        else $error("rotate left wrong");

    rot_left_cy_a: assert property (take_op(OP_RLC) |=>
        acc_o == {$past(acc_o[DW-2:0]), $past(carry_o)} && carry_o == $past(acc_o[DW-1]))
        else $error("rotate left through carry wrong");

    logic_dest_a: assert property (take && dest_mem_i &&
        (op_code_i == OP_AND || op_code_i == OP_OR || op_code_i == OP_XOR)
        |=> mem_we_o && done_o && acc_o == $past(acc_o))
        else $error("memory destination not written");

    and_byte_a: assert property (take_op(OP_AND) ##0 !dest_mem_i |=>
        acc_o == ($past(acc_o) & $past(opnd_i)) && !mem_we_o)
        else $error("byte and wrong");

    or_byte_a: assert property (take_op(OP_OR) ##0 dest_mem_i |=>
        mem_data_o == ($past(dst_i) | $past(opnd_i)))
        else $error("byte or wrong");

    xor_byte_a: assert property (take_op(OP_XOR) ##0 !dest_mem_i |=>
        acc_o == ($past(acc_o) ^ $past(opnd_i)))
        else $error("byte xor wrong");

    and_carry_a: assert property (take_op(OP_ANDC) |=>
        carry_o == ($past(carry_o) && $past(bit_i)))
        else $error("carry and bit wrong");

    and_ncarry_a: assert property (take_op(OP_ANDNC) |=>
        carry_o == ($past(carry_o) && !$past(bit_i)))
        else $error("carry and inverted bit wrong");

    or_carry_a: assert property (take_op(OP_ORC) |=>
        carry_o == ($past(carry_o) || $past(bit_i)))
        else $error("carry or bit wrong");

    or_ncarry_a: assert property (take_op(OP_ORNC) |=>
        carry_o == ($past(carry_o) || !$past(bit_i)))
        else $error("carry or inverted bit wrong");

    carry_only_a: assert property (take && (op_code_i == OP_ANDC ||
        op_code_i == OP_ANDNC || op_code_i == OP_ORC || op_code_i == OP_ORNC)
        |=> !mem_we_o && $stable(acc_o) && $stable(mem_data_o))
        else $error("carry logic touched a byte");

    // any code outside the carry ops must leave carry alone, so no hidden xor
    no_xor_bit_a: assert property (take && !(op_code_i inside {OP_RRC, OP_RLC,
        OP_ANDC, OP_ANDNC, OP_ORC, OP_ORNC, OP_DA, OP_ADD, OP_ADDC, OP_LDC})
        |=> $stable(carry_o))
        else $error("carry moved by an op without carry logic");

    exchange_a: assert property (take_op(OP_XCH) |=>
        acc_o == $past(dst_i) && mem_data_o == $past(acc_o) && mem_we_o)
        else $error("exchange wrong");

    swap_four_a: assert property (rl_four |=>
        acc_o == {$past(acc_o[NW-1:0], 4), $past(acc_o[DW-1:NW], 4)})
        else $error("four left rotations differ from swap");

    swap_nib_a: assert property (take_op(OP_SWAP) |=>
        acc_o == {$past(acc_o[NW-1:0]), $past(acc_o[DW-1:NW])})
        else $error("nibble swap wrong");

    low_xch_a: assert property (take_op(OP_LOW_NIBBLE_EXCHANGE) |=>
        acc_o == {$past(acc_o[DW-1:NW]), $past(dst_i[NW-1:0])}
        && mem_data_o == {$past(dst_i[DW-1:NW]), $past(acc_o[NW-1:0])} && mem_we_o)
        else $error("low nibble exchange wrong");

    da_keep_a: assert property (take && op_code_i == OP_DA && !carry_o
        && !half_carry_o && acc_o[NW-1:0] <= `ARLU_BCD_MAX && acc_o[DW-1:NW] <= `ARLU_BCD_MAX
        |=> $stable(acc_o) && !carry_o)
        else $error("adjust changed a valid BCD value");

    half_carry_a: assert property (take_op(OP_ADD) |=>
        half_carry_o == (({1'b0, $past(acc_o[NW-1:0])} + {1'b0, $past(opnd_i[NW-1:0])})
        > {1'b0, {NW{1'b1}}}))
        else $error("half carry wrong");

    da_low_a: assert property (take_op(OP_DA) ##0 acc_o[NW-1:0] > `ARLU_BCD_MAX
        |=> acc_o[NW-1:0] == $past(acc_o[NW-1:0]) + 4'h6)
        else $error("low nibble not corrected");

    da_carry_a: assert property (take_op(OP_DA) ##0 acc_o[DW-1:NW] > `ARLU_BCD_MAX
        |=> carry_o)
        else $error("high correction did not set carry");

    freeze_a: assert property (!ce_i |=> $stable(acc_o) && $stable(carry_o) && $stable(done_o))
        else $error("state moved while clock enable low");

    sequence bcd_add;
        take && op_code_i == OP_ADD
        && acc_o[DW-1:NW] <= `ARLU_BCD_MAX && acc_o[NW-1:0] <= `ARLU_BCD_MAX
        && opnd_i[DW-1:NW] <= `ARLU_BCD_MAX && opnd_i[NW-1:0] <= `ARLU_BCD_MAX;
    endsequence

    sequence add_then_adjust;
        bcd_add ##1 take_op(OP_DA);
    endsequence

    // the adjusted sum of two valid bcd bytes is itself valid bcd
    bcd_result_a: assert property (add_then_adjust |=>
        acc_o[DW-1:NW] <= `ARLU_BCD_MAX && acc_o[NW-1:0] <= `ARLU_BCD_MAX)
        else $error("adjusted sum is not packed BCD");

    done_pulse_a: assert property (take |=> done_o)
        else $error("accepted op gave no done");

    idle_quiet_a: assert property (ce_i && !op_valid_i |=> !done_o && !mem_we_o)
        else $error("pulse without a request");

    mem_hold_a: assert property (!mem_we_o |-> $stable(mem_data_o))
        else $error("write data moved without a strobe");

    acc_dest_a: assert property (take && !dest_mem_i &&
        (op_code_i == OP_AND || op_code_i == OP_OR || op_code_i == OP_XOR)
        |=> !mem_we_o && $stable(mem_data_o))
        else $error("accumulator destination wrote memory");

    and_mem_a: assert property (take && op_code_i == OP_AND && dest_mem_i |=>
        mem_data_o == ($past(dst_i) & $past(opnd_i)))
        else $error("byte and into memory wrong");

    or_acc_a: assert property (take && op_code_i == OP_OR && !dest_mem_i |=>
        acc_o == ($past(acc_o) | $past(opnd_i)))
        else $error("byte or into accumulator wrong");

    xor_mem_a: assert property (take && op_code_i == OP_XOR && dest_mem_i |=>
        mem_data_o == ($past(dst_i) ^ $past(opnd_i)))
        else $error("byte xor into memory wrong");

    addc_half_a: assert property (take_op(OP_ADDC) |=>
        half_carry_o == (({1'b0, $past(acc_o[NW-1:0])} + {1'b0, $past(opnd_i[NW-1:0])}
        + {{NW{1'b0}}, $past(carry_o)}) > {1'b0, {NW{1'b1}}}))
        else $error("half carry with carry in wrong");

    half_keep_a: assert property (take && op_code_i != OP_ADD &&
        op_code_i != OP_ADDC |=> $stable(half_carry_o))
        else $error("half carry moved outside an addition");

    da_half_a: assert property (take && op_code_i == OP_DA && half_carry_o
        |=> acc_o[NW-1:0] == $past(acc_o[NW-1:0]) + 4'h6)
        else $error("half carry did not force low correction");

    da_sticky_a: assert property (take && op_code_i == OP_DA && carry_o |=> carry_o)
        else $error("adjust cleared carry");

endmodule : arlu_top

`default_nettype wire

// ==== arlu_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module arlu_tb_top
    import arlu_pkg::*;
;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    logic op_valid_i = 1'b0;
    arlu_op_t op_code_i = OP_NOP;
    logic [7:0] opnd_i = 8'h00;
    logic [7:0] dst_i = 8'h00;
    logic dest_mem_i = 1'b0;
    logic bit_i = 1'b0;
    logic [7:0] acc_o;
    logic [7:0] mem_data_o;
    logic carry_o;
    logic half_carry_o;
    logic mem_we_o;
    logic done_o;
    int n_mismatch = 0;
    int n_compared = 0;

    arlu_top #(.DW(8)) dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .op_valid_i(op_valid_i), .op_code_i(op_code_i), .opnd_i(opnd_i),
        .dst_i(dst_i), .dest_mem_i(dest_mem_i), .bit_i(bit_i),
        .acc_o(acc_o), .carry_o(carry_o), .half_carry_o(half_carry_o),
        .mem_data_o(mem_data_o), .mem_we_o(mem_we_o), .done_o(done_o)
    );

    always #2 clock_i = ~clock_i;

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chkb(input string nm, input logic got, input logic exp);
        chk(nm, {7'h00, got}, {7'h00, exp});
    endtask : chkb

    // valid stays high between back-to-back ops; idle lowers it
    task automatic do_op(input arlu_op_t c, input logic [7:0] o, input logic [7:0] d,
                         input logic m, input logic b, input logic we);
        op_code_i = c;
        opnd_i = o;
        dst_i = d;
        dest_mem_i = m;
        bit_i = b;
        op_valid_i = 1'b1;
        @(posedge clock_i);
        #1;
        chkb("done", done_o, 1'b1);
        chkb("mem_we", mem_we_o, we);
    endtask : do_op

    task automatic idle;
        op_valid_i = 1'b0;
        @(posedge clock_i);
        #1;
    endtask : idle

    task automatic lda(input logic [7:0] v);
        do_op(OP_LDA, v, 8'h00, 1'b0, 1'b0, 1'b0);
    endtask : lda

    task automatic ldc(input logic v);
        do_op(OP_LDC, 8'h00, 8'h00, 1'b0, v, 1'b0);
    endtask : ldc

    task automatic t_reset;
        chk("acc", acc_o, 8'h00);
        chk("mem", mem_data_o, 8'h00);
        chkb("cy", carry_o, 1'b0);
        chkb("ac", half_carry_o, 1'b0);
        chkb("done", done_o, 1'b0);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_rotate;
        lda(8'h80);
        ldc(1'b1);
        do_op(OP_RR, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("rr acc", acc_o, 8'h40);
        chkb("rr cy", carry_o, 1'b1);
        lda(8'h81);
        ldc(1'b0);
        do_op(OP_RL, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("rl acc", acc_o, 8'h03);
        chkb("rl cy", carry_o, 1'b0);
        do_op(OP_RRC, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("rrc acc", acc_o, 8'h01);
        chkb("rrc cy", carry_o, 1'b1);
        do_op(OP_RLC, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("rlc acc", acc_o, 8'h03);
        chkb("rlc cy", carry_o, 1'b0);
        idle();
        $display("test rotate finished");
    endtask : t_rotate

    task automatic t_logic;
        arlu_op_t ops[3] = '{OP_AND, OP_OR, OP_XOR};
        logic [7:0] ea;
        logic [7:0] em;
        for (int i = 0; i < 3; i++) begin
            case (i)
                0: begin
                    ea = 8'h5C & 8'h3A;
                    em = 8'hC6 & 8'h3A;
                end
                1: begin
                    ea = 8'h5C | 8'h3A;
                    em = 8'hC6 | 8'h3A;
                end
                default: begin
                    ea = 8'h5C ^ 8'h3A;
                    em = 8'hC6 ^ 8'h3A;
                end
            endcase
            lda(8'h5C);
            do_op(ops[i], 8'h3A, 8'hC6, 1'b1, 1'b0, 1'b1);
            chk("logic mem", mem_data_o, em);
            chk("logic acc kept", acc_o, 8'h5C);
            do_op(ops[i], 8'h3A, 8'hC6, 1'b0, 1'b0, 1'b0);
            chk("logic acc", acc_o, ea);
        end
        idle();
        $display("test logic finished");
    endtask : t_logic

    task automatic t_carry;
        arlu_op_t ops[4] = '{OP_ANDC, OP_ANDNC, OP_ORC, OP_ORNC};
        logic c;
        logic b;
        logic e;
        lda(8'hA5);
        for (int k = 0; k < 16; k++) begin
            c = k[1];
            b = k[0];
            case (k >> 2)
                0: e = c & b;
                1: e = c & ~b;
                2: e = c | b;
                default: e = c | ~b;
            endcase
            ldc(c);
            do_op(ops[k >> 2], 8'h00, 8'h00, 1'b0, b, 1'b0);
            chkb("carry op", carry_o, e);
            chk("carry op acc", acc_o, 8'hA5);
        end
        // an xor of carry with the bit would clear it here
        ldc(1'b1);
        do_op(arlu_op_t'(5'h1F), 8'h00, 8'h00, 1'b0, 1'b1, 1'b0);
        chkb("no carry xor", carry_o, 1'b1);
        idle();
        $display("test carry finished");
    endtask : t_carry

    task automatic t_exchange;
        lda(8'h25);
        do_op(OP_XCH, 8'h00, 8'h45, 1'b0, 1'b0, 1'b1);
        chk("xch acc", acc_o, 8'h45);
        chk("xch mem", mem_data_o, 8'h25);
        lda(8'h24);
        do_op(OP_LOW_NIBBLE_EXCHANGE, 8'h00, 8'h87, 1'b0, 1'b0, 1'b1);
        chk("low_nibble_exchange acc", acc_o, 8'h27);
        chk("low_nibble_exchange mem", mem_data_o, 8'h84);
        lda(8'hF7);
        do_op(OP_SWAP, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("swap", acc_o, 8'h7F);
        for (int i = 0; i < 4; i++) begin
            do_op(OP_RL, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
        end
        chk("four rl", acc_o, 8'hF7);
        idle();
        $display("test exchange finished");
    endtask : t_exchange

    task automatic t_decimal;
        logic [7:0] av[5] = '{8'h38, 8'h2E, 8'h19, 8'h99, 8'h80};
        logic [7:0] bv[5] = '{8'h25, 8'h05, 8'h28, 8'h01, 8'h90};
        logic [8:0] s;
        logic h;
        for (int i = 0; i < 5; i++) begin
            s = {1'b0, av[i]} + {1'b0, bv[i]};
            h = ({1'b0, av[i][3:0]} + {1'b0, bv[i][3:0]}) > 5'h0F;
            lda(av[i]);
            do_op(OP_ADD, bv[i], 8'h00, 1'b0, 1'b0, 1'b0);
            chk("add acc", acc_o, s[7:0]);
            chkb("add ac", half_carry_o, h);
            if (s[3:0] > 4'h9 || h) begin
                s = s + 9'h006;
            end
            if (s[7:4] > 4'h9 || s[8]) begin
                s = s + 9'h060;
                s[8] = 1'b1;
            end
            do_op(OP_DA, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
            chk("da acc", acc_o, s[7:0]);
            chkb("da cy", carry_o, s[8]);
        end
        // carry is set here: 70 + 0F + 1 carries out of the low nibble
        do_op(OP_ADDC, 8'h0F, 8'h00, 1'b0, 1'b0, 1'b0);
        chk("addc acc", acc_o, 8'h80);
        chkb("addc ac", half_carry_o, 1'b1);
        chkb("addc cy", carry_o, 1'b0);
        idle();
        $display("test decimal finished");
    endtask : t_decimal

    // clock enable low must swallow a request without trace
    task automatic t_hold;
        lda(8'h11);
        idle();
        ce_i = 1'b0;
        op_code_i = OP_LDA;
        opnd_i = 8'h55;
        op_valid_i = 1'b1;
        @(posedge clock_i);
        #1;
        chk("held acc", acc_o, 8'h11);
        chkb("held done", done_o, 1'b0);
        ce_i = 1'b1;
        op_valid_i = 1'b0;
        @(posedge clock_i);
        #1;
        chkb("idle done", done_o, 1'b0);
        $display("test hold finished");
    endtask : t_hold

    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        t_reset();
        t_rotate();
        t_logic();
        t_carry();
        t_exchange();
        t_decimal();
        t_hold();
        end_sim();
    end
endmodule : arlu_tb_top

`default_nettype wire
